// ### hdl/wwd_calc.sv
// timeout calculator: least and longest timeout in oscillator periods
`timescale 1ns/10ps
`include "wwd_cfg.svh"
`default_nettype none
module wwd_calc (
	// clock and reset
	input  wire logic aclk,
	input  wire logic aresetn,
	// setting in, timeouts out
	wwd_calc_if.calc  cif
);
	logic [7:0]  coarse;
	logic [7:0]  fine;
	logic [7:0]  quarter;
	logic [7:0]  cnt8;
	logic [7:0]  quot;
	logic [23:0] base_min;
	logic [23:0] lin;
	logic [23:0] mix;

	always_comb begin
		case (cif.timebase_select)
			2'h0: begin coarse = `WWD_COARSE_0; fine = `WWD_FINE_0; end
			2'h1: begin coarse = `WWD_COARSE_1; fine = `WWD_FINE_1; end
			2'h2: begin coarse = `WWD_COARSE_2; fine = `WWD_FINE_2; end
			default: begin coarse = `WWD_COARSE_3; fine = `WWD_FINE_3; end
		endcase
	end

	assign cnt8 = {2'h0, cif.count_setting};
	assign quarter = coarse >> 2;
	assign quot = 8'({cnt8[5:0], 2'h0} / coarse);
	// offset of the least timeout only; the longest starts from WWD_TMAX0
	assign base_min = 24'((24'(fine) + `WWD_FINE_BASE) << `WWD_FINE_SHIFT);
	assign lin = 24'(24'(cnt8) << `WWD_CNT_SHIFT);
	assign mix = 24'((24'(cnt8 - quot) << `WWD_CNT_SHIFT)
		+ (((`WWD_CORR_BASE + 24'(fine)) << `WWD_FINE_SHIFT) * 24'(quot)));

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			cif.t_min <= 24'h000000;
			cif.t_max <= 24'h000000;
		end else begin
			cif.t_min <= (cnt8 < quarter) ? base_min + lin : base_min + mix;
			cif.t_max <= (cnt8 <= quarter) ? `WWD_TMAX0 + lin : `WWD_TMAX0 + mix;
		end
	end

	property p_tmax_zero;
		@(posedge aclk) disable iff (!aresetn)
		(cif.count_setting == 6'h00) |=> (cif.t_max == `WWD_TMAX0);
	endproperty
	a_tmax_zero: assert property (p_tmax_zero) else $error("longest timeout wrong at zero count");
endmodule : wwd_calc
`default_nettype wire

// ### hdl/wwd_calc_if.sv
// carrier between the watchdog core and its timeout calculator
`timescale 1ns/10ps
`default_nettype none
interface wwd_calc_if;
	logic [5:0]  count_setting;
	logic [1:0]  timebase_select;
	logic [23:0] t_min;
	logic [23:0] t_max;
	modport calc (input count_setting, input timebase_select, output t_min, output t_max);
	modport core (output count_setting, output timebase_select, input t_min, input t_max);
endinterface : wwd_calc_if
`default_nettype wire

// ### hdl/wwd_cfg.svh
// constants of the window watchdog: register indices, fields, reset values, timing
`ifndef WWD_CFG_SVH
`define WWD_CFG_SVH
`define WWD_IDX_CTRL 8'h2F
`define WWD_IDX_WIN 8'h30
`define WWD_IDX_OPT 8'h31
`define WWD_IDX_STAT 8'h32
`define WWD_IDX_TMIN 8'h33
`define WWD_IDX_TMAX 8'h34
`define WWD_CTRL_RST 7'h7F
`define WWD_WIN_RST 7'h7F
`define WWD_OPT_RST 6'h00
`define WWD_ROLL_VAL 7'h40
`define WWD_BIT_ACT 7
`define WWD_BIT_TOP 6
`define WWD_OPT_HW 0
`define WWD_OPT_HRO 1
`define WWD_OPT_TB_LO 2
`define WWD_OPT_TB_HI 3
`define WWD_OPT_OIE 4
`define WWD_OPT_LONG 5
`define WWD_RESP_OK 2'h0
`define WWD_RESP_ERR 2'h2
`define WWD_PRESCALE 16384
`define WWD_RESUME_SHORT 13'h0100
`define WWD_RESUME_LONG 13'h1000
`define WWD_TMAX0 24'h004000
`define WWD_FINE_BASE 24'h000080
`define WWD_CORR_BASE 24'h0000C0
`define WWD_CNT_SHIFT 14
`define WWD_FINE_SHIFT 6
`define WWD_COARSE_0 8'h04
`define WWD_FINE_0 8'h3B
`define WWD_COARSE_1 8'h08
`define WWD_FINE_1 8'h35
`define WWD_COARSE_2 8'h14
`define WWD_FINE_2 8'h23
`define WWD_COARSE_3 8'h31
`define WWD_FINE_3 8'h36
`endif

// ### hdl/wwd_pkg.sv
// types of the window watchdog
package wwd_pkg;
	typedef enum logic [2:0] {ST_RUN, ST_HALT_ONE, ST_HALTED, ST_ACT_HALT, ST_RESUME} wwd_state_t;
endpackage : wwd_pkg

// ### hdl/wwd_top.sv
// window watchdog core with axi4-lite register slave
`timescale 1ns/10ps
`include "wwd_cfg.svh"
`default_nettype none
module wwd_top #(
	parameter int ADDR_W   = 12,
	parameter int PRESCALE = `WWD_PRESCALE
) (
	// clock and reset
	input  wire logic              aclk,
	input  wire logic              aresetn,
	// axi4-lite write channels
	input  wire logic [ADDR_W-1:0] s_axi_awaddr,
	input  wire logic              s_axi_awvalid,
	output logic                   s_axi_awready,
	input  wire logic [31:0]       s_axi_wdata,
	input  wire logic [3:0]        s_axi_wstrb,
	input  wire logic              s_axi_wvalid,
	output logic                   s_axi_wready,
	output logic [1:0]             s_axi_bresp,
	output logic                   s_axi_bvalid,
	input  wire logic              s_axi_bready,
	// axi4-lite read channels
	input  wire logic [ADDR_W-1:0] s_axi_araddr,
	input  wire logic              s_axi_arvalid,
	output logic                   s_axi_arready,
	output logic [31:0]            s_axi_rdata,
	output logic [1:0]             s_axi_rresp,
	output logic                   s_axi_rvalid,
	input  wire logic              s_axi_rready,
	// processor power events
	input  wire logic              halt_req,
	input  wire logic              irq_wake,
	input  wire logic              halt_exit_reset,
	// chip reset request
	output logic                   wdg_reset
);
	localparam int PRE_W = $clog2(PRESCALE);

	if (PRESCALE < 2 || ADDR_W < 10) begin : g_chk
		$error("wwd_top: PRESCALE must be 2 or more and ADDR_W 10 or more");
	end

	wwd_pkg::wwd_state_t state_reg;
	logic [PRE_W-1:0]    pre_reg;
	logic [6:0]          cnt_reg;
	logic [6:0]          win_reg;
	logic                act_reg;
	logic [5:0]          opt_reg;
	logic [12:0]         resume_reg;
	logic [12:0]         dwell_reg;
	logic                wdg_reset_reg;
	logic                aw_hold_reg;
	logic [ADDR_W-1:0]   awaddr_reg;
	logic                w_hold_reg;
	logic [7:0]          wdata_reg;
	logic                wstrb_reg;
	logic                bvalid_reg;
	logic [1:0]          bresp_reg;
	logic                rvalid_reg;
	logic [1:0]          rresp_reg;
	logic [31:0]         rdata_reg;
	logic [31:0]         rd_val;
	logic [7:0]          wr_idx;
	logic [7:0]          rd_idx;
	logic                do_wr;
	logic                ctrl_wr;
	logic                tick;
	logic                count_en;
	logic                active;
	logic                in_run;
	logic                oscillator_irq_enable;
	logic                hro;
	logic                rollover;
	logic                early;
	logic                swrst;
	logic                halt_rst;
	logic [12:0]         resume_tgt;
	logic                in_plain_halt;

	wwd_calc_if cif ();

	// shared address decode for both directions
	function automatic logic mapped(input logic [7:0] idx, input logic wr);
		case (idx)
			`WWD_IDX_CTRL, `WWD_IDX_WIN, `WWD_IDX_OPT: mapped = 1'b1;
			`WWD_IDX_STAT, `WWD_IDX_TMIN, `WWD_IDX_TMAX: mapped = !wr;
			default: mapped = 1'b0;
		endcase
	endfunction : mapped

	function automatic logic wr_hits(input logic [7:0] idx, input logic [7:0] reg_idx, input logic go);
		wr_hits = go && (idx == reg_idx);
	endfunction : wr_hits

	// write address and data are taken in either order, answered together
	assign s_axi_awready = !aw_hold_reg && !bvalid_reg;
	assign s_axi_wready  = !w_hold_reg && !bvalid_reg;
	assign do_wr         = aw_hold_reg && w_hold_reg && !bvalid_reg;
	assign wr_idx        = awaddr_reg[9:2];
	assign ctrl_wr       = wr_hits(wr_idx, `WWD_IDX_CTRL, do_wr && wstrb_reg);
	assign s_axi_bvalid  = bvalid_reg;
	assign s_axi_bresp   = bresp_reg;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_hold_reg <= 1'b0;
			awaddr_reg  <= '0;
		end else if (s_axi_awvalid && s_axi_awready) begin
			aw_hold_reg <= 1'b1;
			awaddr_reg  <= s_axi_awaddr;
		end else if (do_wr) begin
			aw_hold_reg <= 1'b0;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			w_hold_reg <= 1'b0;
			wdata_reg  <= 8'h00;
			wstrb_reg  <= 1'b0;
		end else if (s_axi_wvalid && s_axi_wready) begin
			w_hold_reg <= 1'b1;
			wdata_reg  <= s_axi_wdata[7:0];
			wstrb_reg  <= s_axi_wstrb[0];
		end else if (do_wr) begin
			w_hold_reg <= 1'b0;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			bvalid_reg <= 1'b0;
			bresp_reg  <= `WWD_RESP_OK;
		end else if (do_wr) begin
			bvalid_reg <= 1'b1;
			bresp_reg  <= mapped(wr_idx, 1'b1) ? `WWD_RESP_OK : `WWD_RESP_ERR;
		end else if (s_axi_bready) begin
			bvalid_reg <= 1'b0;
		end
	end

	// read side: one word in flight, answer one cycle after the address
	assign s_axi_arready = !rvalid_reg;
	assign s_axi_rvalid  = rvalid_reg;
	assign s_axi_rresp   = rresp_reg;
	assign s_axi_rdata   = rdata_reg;
	assign rd_idx        = s_axi_araddr[9:2];

	always_comb begin
		case (rd_idx)
			`WWD_IDX_CTRL: rd_val = {24'h000000, act_reg, cnt_reg};
			`WWD_IDX_WIN:  rd_val = {25'h0000000, win_reg};
			`WWD_IDX_OPT:  rd_val = {26'h0000000, opt_reg};
			`WWD_IDX_STAT: rd_val = {27'h0000000, active, state_reg == wwd_pkg::ST_RESUME,
				state_reg == wwd_pkg::ST_ACT_HALT, in_plain_halt, in_run};
			`WWD_IDX_TMIN: rd_val = {8'h00, cif.t_min};
			`WWD_IDX_TMAX: rd_val = {8'h00, cif.t_max};
			default:       rd_val = 32'h00000000;
		endcase
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rvalid_reg <= 1'b0;
			rresp_reg  <= `WWD_RESP_OK;
			rdata_reg  <= 32'h00000000;
		end else if (s_axi_arvalid && s_axi_arready) begin
			rvalid_reg <= 1'b1;
			rresp_reg  <= mapped(rd_idx, 1'b0) ? `WWD_RESP_OK : `WWD_RESP_ERR;
			rdata_reg  <= rd_val;
		end else if (s_axi_rready) begin
			rvalid_reg <= 1'b0;
		end
	end

	// option, window and timebase registers
	assign oscillator_irq_enable    = opt_reg[`WWD_OPT_OIE];
	assign hro    = opt_reg[`WWD_OPT_HRO];
	assign active = opt_reg[`WWD_OPT_HW] | act_reg;
	assign cif.count_setting   = cnt_reg[5:0];
	assign cif.timebase_select = opt_reg[`WWD_OPT_TB_HI:`WWD_OPT_TB_LO];

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			opt_reg <= `WWD_OPT_RST;
			win_reg <= `WWD_WIN_RST;
		end else begin
			if (wr_hits(wr_idx, `WWD_IDX_OPT, do_wr && wstrb_reg)) begin
				opt_reg <= wdata_reg[5:0];
			end
			if (wr_hits(wr_idx, `WWD_IDX_WIN, do_wr && wstrb_reg)) begin
				win_reg <= wdata_reg[6:0];
			end
		end
	end

	// prescaler runs on the oscillator clock, not the slowed cpu clock
	assign tick = pre_reg == PRE_W'(PRESCALE - 1);

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			pre_reg <= '0;
		end else begin
			pre_reg <= tick ? '0 : PRE_W'(pre_reg + 1'b1);
		end
	end

	assign in_run        = state_reg == wwd_pkg::ST_RUN;
	assign in_plain_halt = (state_reg == wwd_pkg::ST_HALT_ONE) || (state_reg == wwd_pkg::ST_HALTED);
	// counting stops in halt except the single step
	assign count_en = in_run || (state_reg == wwd_pkg::ST_HALT_ONE);

	// counter and activation; the prescaler is not cleared on refresh, hence min/max spread
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			cnt_reg <= `WWD_CTRL_RST;
			act_reg <= 1'b0;
		end else if (halt_exit_reset && in_plain_halt) begin
			cnt_reg <= `WWD_CTRL_RST;
			act_reg <= 1'b0;
		end else if (ctrl_wr) begin
			cnt_reg <= wdata_reg[6:0];
			act_reg <= act_reg | wdata_reg[`WWD_BIT_ACT];
		end else if (tick && count_en) begin
			cnt_reg <= cnt_reg - 7'h01;
		end
	end

	assign rollover = in_run && active && tick && !ctrl_wr && (cnt_reg == `WWD_ROLL_VAL);
	assign early    = ctrl_wr && in_run && active && (cnt_reg > win_reg);
	// clearing the top bit in run, while active or with the activation bit, is a software reset
	assign swrst    = ctrl_wr && in_run && (active || wdata_reg[`WWD_BIT_ACT]) && !wdata_reg[`WWD_BIT_TOP];
	assign halt_rst = halt_req && in_run && !oscillator_irq_enable && hro && active;

	// reset request is the only outcome
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			wdg_reset_reg <= 1'b0;
		end else begin
			wdg_reset_reg <= rollover | early | swrst | halt_rst;
		end
	end
	assign wdg_reset = wdg_reset_reg;

	assign resume_tgt = opt_reg[`WWD_OPT_LONG] ? `WWD_RESUME_LONG : `WWD_RESUME_SHORT;

	// power-mode sequencing
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			state_reg  <= wwd_pkg::ST_RUN;
			resume_reg <= 13'h0000;
		end else begin
			case (state_reg)
				wwd_pkg::ST_RUN: begin
					if (halt_req && oscillator_irq_enable) begin
						state_reg <= wwd_pkg::ST_ACT_HALT;
					end else if (halt_req && !halt_rst) begin
						state_reg <= wwd_pkg::ST_HALT_ONE;
					end
				end
				wwd_pkg::ST_HALT_ONE, wwd_pkg::ST_HALTED: begin
					if (halt_exit_reset) begin
						state_reg <= wwd_pkg::ST_RUN;
					end else if (irq_wake) begin
						state_reg  <= wwd_pkg::ST_RESUME;
						resume_reg <= 13'(resume_tgt - 13'h0001);
					end else if (tick) begin
						state_reg <= wwd_pkg::ST_HALTED;
					end
				end
				wwd_pkg::ST_ACT_HALT: begin
					if (irq_wake) begin
						state_reg <= wwd_pkg::ST_RUN;
					end else if (halt_exit_reset) begin
						state_reg  <= wwd_pkg::ST_RESUME;
						resume_reg <= 13'(resume_tgt - 13'h0001);
					end
				end
				wwd_pkg::ST_RESUME: begin
					if (resume_reg == 13'h0000) begin
						state_reg <= wwd_pkg::ST_RUN;
					end else begin
						resume_reg <= resume_reg - 13'h0001;
					end
				end
				default: state_reg <= wwd_pkg::ST_RUN;
			endcase
		end
	end

	wwd_calc u_calc (
		.aclk    (aclk),
		.aresetn (aresetn),
		.cif     (cif.calc)
	);

	// helper: cycles spent in the resume wait
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			dwell_reg <= 13'h0000;
		end else begin
			dwell_reg <= (state_reg == wwd_pkg::ST_RESUME) ? 13'(dwell_reg + 13'h0001) : 13'h0000;
		end
	end

	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	property p_roll;
		(in_run && active && tick && !ctrl_wr && cnt_reg == `WWD_ROLL_VAL) |=> wdg_reset;
	endproperty
	a_roll: assert property (p_roll) else $error("no reset on rollover");

	property p_early;
		(ctrl_wr && in_run && active && cnt_reg > win_reg) |=> wdg_reset;
	endproperty
	a_early: assert property (p_early) else $error("no reset on early refresh");

	property p_halt_rst;
		(halt_req && in_run && !oscillator_irq_enable && hro && active) |=> (wdg_reset && in_run);
	endproperty
	a_halt_rst: assert property (p_halt_rst) else $error("halt did not become reset");

	property p_act_halt;
		(halt_req && in_run && oscillator_irq_enable) |=> (state_reg == wwd_pkg::ST_ACT_HALT) && !wdg_reset;
	endproperty
	a_act_halt: assert property (p_act_halt) else $error("active halt not entered");

	property p_act_stop;
		(state_reg == wwd_pkg::ST_ACT_HALT && !ctrl_wr) |=> cnt_reg == $past(cnt_reg);
	endproperty
	a_act_stop: assert property (p_act_stop) else $error("counter moved in active halt");

	property p_halted_stop;
		(state_reg == wwd_pkg::ST_HALTED && !ctrl_wr && !halt_exit_reset) |=> cnt_reg == $past(cnt_reg);
	endproperty
	a_halted_stop: assert property (p_halted_stop) else $error("counter moved in halt");

	property p_halt_quiet;
		wdg_reset |-> $past(in_run);
	endproperty
	a_halt_quiet: assert property (p_halt_quiet) else $error("reset raised outside run");

	property p_resume_len;
		($past(state_reg) == wwd_pkg::ST_RESUME && in_run) |-> $past(dwell_reg) == 13'($past(resume_tgt) - 13'h0001);
	endproperty
	a_resume_len: assert property (p_resume_len) else $error("resume wait length wrong");

	property p_rst_wake;
		(halt_exit_reset && state_reg == wwd_pkg::ST_ACT_HALT) |=> state_reg == wwd_pkg::ST_RESUME;
	endproperty
	a_rst_wake: assert property (p_rst_wake) else $error("reset wake skipped delay");

	property p_disable;
		(halt_exit_reset && in_plain_halt) |=> !act_reg && cnt_reg == `WWD_CTRL_RST && in_run;
	endproperty
	a_disable: assert property (p_disable) else $error("not back in reset state");

	property p_hw;
		(opt_reg[`WWD_OPT_HW] && !act_reg && in_run && tick && !ctrl_wr && cnt_reg == `WWD_ROLL_VAL) |=> wdg_reset;
	endproperty
	a_hw: assert property (p_hw) else $error("hardware option not active");

	property p_step;
		(in_run && tick && !ctrl_wr) |=> cnt_reg == 7'($past(cnt_reg) - 7'h01);
	endproperty
	a_step: assert property (p_step) else $error("counter missed a step");

	c_roll: cover property (rollover ##1 wdg_reset);
	c_early: cover property (early ##1 wdg_reset);
	c_act_wake: cover property (state_reg == wwd_pkg::ST_ACT_HALT ##1 irq_wake ##1 in_run);
	c_resume: cover property (state_reg == wwd_pkg::ST_RESUME ##1 in_run);
endmodule : wwd_top
`default_nettype wire

// ### test/wwd_top_tb.sv
// self-checking bench of the window watchdog over axi4-lite
`timescale 1ns/10ps
`include "wwd_cfg.svh"
`default_nettype none
module wwd_top_tb;
	localparam int PS = 64;
	localparam logic [11:0] A_CTRL = {2'h0, `WWD_IDX_CTRL, 2'h0};
	localparam logic [11:0] A_WIN  = {2'h0, `WWD_IDX_WIN, 2'h0};
	localparam logic [11:0] A_OPT  = {2'h0, `WWD_IDX_OPT, 2'h0};
	localparam logic [11:0] A_STAT = {2'h0, `WWD_IDX_STAT, 2'h0};
	localparam logic [11:0] A_TMIN = {2'h0, `WWD_IDX_TMIN, 2'h0};
	localparam logic [11:0] A_TMAX = {2'h0, `WWD_IDX_TMAX, 2'h0};
	logic aclk = 1'b0, aresetn = 1'b0;
	logic [11:0] awaddr = 12'h0, araddr = 12'h0;
	logic [31:0] wdata = 32'h0, rdata;
	logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
	logic awready, wready, bvalid, arready, rvalid, wdg_reset;
	logic [1:0] bresp, rresp, rsp;
	logic [2:0] ev = 3'h0;
	logic [31:0] d, c0, c1;
	int miscompares = 0, cmp_count = 0, rst_cnt = 0, r0;
	logic [7:0] cnts [3];
	always #5 aclk = ~aclk;
	// chip reset requests seen so far
	always @(posedge aclk) if (wdg_reset === 1'b1) rst_cnt <= rst_cnt + 1;
	wwd_top #(.ADDR_W(12), .PRESCALE(PS)) u_wwd_top (.aclk(aclk), .aresetn(aresetn),
		.s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
		.s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
		.s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
		.s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
		.s_axi_rready(rready), .halt_req(ev[2]), .irq_wake(ev[1]), .halt_exit_reset(ev[0]),
		.wdg_reset(wdg_reset));
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		cmp_count++;
		if (g !== e) begin
			miscompares++;
			$display("[ERR] %s expected %h seen %h", nm, e, g);
		end
	endtask : chk
	task automatic wr(input logic [11:0] a, input logic [7:0] v);
		logic aw_hs, w_hs;
		@(posedge aclk);
		awaddr <= a; wdata <= {24'h0, v}; awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1;
		#1;
		while (awvalid || wvalid) begin
			aw_hs = awvalid && awready;
			w_hs = wvalid && wready;
			@(posedge aclk);
			if (aw_hs) awvalid <= 1'b0;
			if (w_hs) wvalid <= 1'b0;
			#1;
		end
		while (bvalid !== 1'b1) begin @(posedge aclk); #1; end
		rsp = bresp;
		@(posedge aclk);
		bready <= 1'b0;
	endtask : wr
	task automatic rd(input logic [11:0] a);
		@(posedge aclk);
		araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
		#1;
		while (!(arvalid && arready)) begin @(posedge aclk); #1; end
		@(posedge aclk);
		arvalid <= 1'b0;
		#1;
		while (rvalid !== 1'b1) begin @(posedge aclk); #1; end
		d = rdata; rsp = rresp;
		@(posedge aclk);
		rready <= 1'b0;
	endtask : rd
	task automatic pulse(input logic [2:0] m);
		@(posedge aclk); ev <= m;
		@(posedge aclk); ev <= 3'h0;
	endtask : pulse
	task automatic do_reset();
		@(posedge aclk); aresetn <= 1'b0;
		repeat (10) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
	endtask : do_reset
	// expected timeout: divisions truncate, quarter of coarse as the switch point
	function automatic logic [23:0] tmo(input logic [5:0] c, input logic [1:0] tb, input bit mx);
		logic [7:0] co [4];
		logic [7:0] fi [4];
		logic [23:0] k, b;
		co = '{`WWD_COARSE_0, `WWD_COARSE_1, `WWD_COARSE_2, `WWD_COARSE_3};
		fi = '{`WWD_FINE_0, `WWD_FINE_1, `WWD_FINE_2, `WWD_FINE_3};
		k = (24'(c) * 24'h4) / 24'(co[tb]);
		b = mx ? 24'h4000 : (24'(fi[tb]) + 24'h80) * 24'h40;
		if (mx ? (c <= co[tb] / 4) : (c < co[tb] / 4)) tmo = b + 24'h4000 * 24'(c);
		else tmo = b + 24'h4000 * (24'(c) - k) + (24'hC0 + 24'(fi[tb])) * 24'h40 * k;
	endfunction : tmo
	task automatic print_verdict();
		$display("comparisons %0d mismatches %0d", cmp_count, miscompares);
		if (miscompares == 0 && cmp_count > 0) $display("Testbench passed");
		else $display("Testbench failed");
		$finish;
	endtask : print_verdict
	// watchdog of the run: the sequence needs well under 30000 cycles
	initial begin
		repeat (60000) @(posedge aclk);
		miscompares++;
		print_verdict();
	end
	initial begin
		repeat (10) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		// reset values and refused accesses
		rd(A_CTRL); chk("ctrl", 32'h7F, d);
		rd(A_WIN); chk("win", 32'h7F, d);
		rd(A_OPT); chk("opt", 32'h00, d);
		rd(12'h000); chk("unmapped", {30'h0, `WWD_RESP_ERR}, {d[29:0], rsp});
		wr(A_STAT, 8'h00); chk("ro write", 32'(`WWD_RESP_ERR), 32'(rsp));
		// frozen in active halt, timeouts per timebase
		for (int tb = 0; tb < 4; tb++) begin
			cnts = '{8'h00, 8'h00, 8'h3F};
			cnts[1] = (tb == 0) ? 8'h01 : (tb == 1) ? 8'h02 : (tb == 2) ? 8'h05 : 8'h0C;
			for (int i = 0; i < 3; i++) begin
				wr(A_OPT, 8'h10 | 8'(tb << 2));
				wr(A_CTRL, 8'h40 | cnts[i]);
				pulse(3'h4);
				rd(A_CTRL); c0 = d;
				rd(A_TMIN); chk("tmin", 32'(tmo(c0[5:0], 2'(tb), 1'b0)), d);
				rd(A_TMAX); chk("tmax", 32'(tmo(c0[5:0], 2'(tb), 1'b1)), d);
				repeat (2 * PS) @(posedge aclk);
				rd(A_CTRL); chk("act halt hold", c0, d);
				rd(A_STAT); chk("act halt stat", 32'h04, d);
				pulse(3'h2);
				rd(A_STAT); chk("act halt wake", 32'h01, d);
			end
		end
		// plain halt steps once, resumes late, reset exit disables
		do_reset();
		wr(A_CTRL, 8'hFF);
		rd(A_CTRL); c0 = d; r0 = rst_cnt;
		pulse(3'h4);
		repeat (3 * PS) @(posedge aclk);
		rd(A_CTRL); c1 = d; chk("halt step", c0 - 32'h1, c1);
		rd(A_STAT); chk("halt stat", 32'h12, d);
		repeat (3 * PS) @(posedge aclk);
		rd(A_CTRL); chk("halt stopped", c1, d);
		pulse(3'h2);
		rd(A_STAT); chk("resume stat", 32'h18, d);
		repeat (200) @(posedge aclk);
		rd(A_CTRL); chk("resume hold", c1, d);
		repeat (100) @(posedge aclk);
		rd(A_STAT); chk("resumed", 32'h11, d);
		chk("no halt reset", 32'(r0), 32'(rst_cnt));
		pulse(3'h4);
		pulse(3'h1);
		rd(A_CTRL); chk("reset exit", 32'h7F, d);
		// halt with reset option while active
		wr(A_OPT, 8'h02);
		wr(A_CTRL, 8'hFF); r0 = rst_cnt;
		pulse(3'h4);
		repeat (4) @(posedge aclk);
		chk("halt reset", 32'(r0 + 1), 32'(rst_cnt));
		rd(A_STAT); chk("no halt", 32'h11, d);
		// reset ending active halt waits the long resume
		wr(A_OPT, 8'h30);
		pulse(3'h4);
		pulse(3'h1);
		repeat (4000) @(posedge aclk);
		rd(A_STAT); chk("long resume", 32'h18, d);
		repeat (200) @(posedge aclk);
		rd(A_STAT); chk("long resumed", 32'h11, d);
		do_reset();
		wr(A_CTRL, 8'hC1); r0 = rst_cnt;
		repeat (3 * PS) @(posedge aclk);
		chk("rollover", 32'(r0 + 1), 32'(rst_cnt));
		// refresh above the window, then inside it
		do_reset();
		wr(A_WIN, 8'h50);
		wr(A_CTRL, 8'hFF); r0 = rst_cnt;
		wr(A_CTRL, 8'hFF);
		repeat (2) @(posedge aclk);
		chk("early refresh", 32'(r0 + 1), 32'(rst_cnt));
		wr(A_WIN, 8'h7F);
		wr(A_CTRL, 8'hFF);
		repeat (2) @(posedge aclk);
		chk("window refresh", 32'(r0 + 1), 32'(rst_cnt));
		// hardware option active without the activation bit
		do_reset();
		wr(A_OPT, 8'h01);
		rd(A_STAT); chk("hw active", 32'h11, d);
		r0 = rst_cnt;
		wr(A_CTRL, 8'h3F);
		repeat (2) @(posedge aclk);
		chk("hw soft reset", 32'(r0 + 1), 32'(rst_cnt));
		print_verdict();
	end
endmodule : wwd_top_tb
`default_nettype wire
